// ---- hdl/mfll_top.sv ----
// fault log, elapsed-time accumulators and parameter lock with ahb-lite registers
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module mfll_top #(
    parameter longint CYCLES_PER_HOUR = mfll_pkg::CYCLES_PER_HOUR
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_reset,
    input wire logic log_shown,
    input wire logic fault_pulse,
    input wire logic [7:0] fault_code,
    input wire logic drive_running,
    output logic [7:0] view_entry,
    output logic [1:0] view_index,
    output logic [7:0] active_fault,
    output logic [15:0] base_freq
);

    // ----------------------------------------------------------------
    // keypad pins: synchronise, then catch rising edges of the three keys; log shown is used as a level
    // ----------------------------------------------------------------
    logic [3:0] keys_sync;  // up, down, reset, log shown
    logic [2:0] keys_prev;  // previous synced key levels
    logic up_hit, down_hit, reset_hit, in_log;

    mfll_sync #(.WIDTH(4)) u_key_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .async_in({log_shown, key_reset, key_down, key_up}),
        .sync_out(keys_sync)
    );

    assign up_hit = keys_sync[0] & ~keys_prev[0];
    assign down_hit = keys_sync[1] & ~keys_prev[1];
    assign reset_hit = keys_sync[2] & ~keys_prev[2];
    assign in_log = keys_sync[3];

    // edge memory
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            keys_prev <= '0;
        else
            keys_prev <= keys_sync[2:0];
    end

    // ----------------------------------------------------------------
    // ahb-lite slave: zero wait states, read data registered
    // ----------------------------------------------------------------
    logic wr_pend, next_wr_pend;       // write data phase pending
    logic [7:0] wr_addr, next_wr_addr; // address of pending write
    logic [31:0] next_hrdata;
    logic addr_ok;
    logic [15:0] wd;                   // low half of write data

    assign addr_ok = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;  // never stretches a transfer
    assign hresp = 1'b0;      // always okay, unmapped reads give zero
    assign wd = hwdata[15:0];

    // ----------------------------------------------------------------
    // parameter and log state
    // ----------------------------------------------------------------
    logic [7:0] flog [mfll_pkg::LOG_DEPTH];      // entry 0 is newest
    logic [7:0] next_flog [mfll_pkg::LOG_DEPTH];
    logic [15:0] preset [mfll_pkg::NUM_PRESETS];
    logic [15:0] next_preset [mfll_pkg::NUM_PRESETS];
    logic [1:0] next_view_index;
    logic [7:0] next_active_fault;
    logic time_mode, next_time_mode;
    logic [1:0] lock_level, next_lock_level;
    logic [15:0] key_code, next_key_code;
    logic unlocked, next_unlocked;
    logic rejected, next_rejected;
    logic [15:0] next_base_freq;
    logic [mfll_pkg::HOUR_CNT_W-1:0] hour_cnt, next_hour_cnt;
    logic [4:0] hours, next_hours;
    logic [15:0] days, next_days;
    logic nonclear;       // active fault survives a manual reset
    logic is_preset, is_param, key_ok, lock_ok, wr_accept;
    logic [2:0] preset_sel;
    logic counting;

    assign nonclear = (active_fault == mfll_pkg::STOPPED_OVERVOLTAGE_FAULT)
        || (active_fault == mfll_pkg::STOPPED_UNDERVOLTAGE_FAULT)
        || (active_fault == mfll_pkg::STOPPED_OVERHEAT_FAULT)
        || (active_fault == mfll_pkg::RUNNING_OVERHEAT_FAULT);
    assign counting = (time_mode == mfll_pkg::TMODE_POWER_ON) || drive_running;
    assign preset_sel = wr_addr[4:2];

    // ----------------------------------------------------------------
    // write permission: key first, then lock level
    // ----------------------------------------------------------------
    always_comb
    begin
        is_preset = (wr_addr >= mfll_pkg::OFS_PRESET0) && (wr_addr <= mfll_pkg::OFS_PRESET_END);
        is_param = is_preset || (wr_addr == mfll_pkg::OFS_TIME_MODE) || (wr_addr == mfll_pkg::OFS_LOCK)
            || (wr_addr == mfll_pkg::OFS_KEY_CODE) || (wr_addr == mfll_pkg::OFS_RESTORE)
            || (wr_addr == mfll_pkg::OFS_BASE_FREQ);
        key_ok = (key_code == mfll_pkg::KEY_NONE) || unlocked;
        case (lock_level)
            mfll_pkg::LOCK_NONE: lock_ok = 1'b1;
            mfll_pkg::LOCK_NO_PRESET: lock_ok = !is_preset;
            mfll_pkg::LOCK_ONLY_PRESET: lock_ok = is_preset;
            default: lock_ok = (wr_addr == mfll_pkg::OFS_LOCK);
        endcase
        wr_accept = wr_pend && is_param && key_ok && lock_ok;
    end

    // ----------------------------------------------------------------
    // next state of bus, log, parameters and accumulators
    // ----------------------------------------------------------------
    always_comb
    begin
        next_wr_pend = addr_ok & hwrite;
        next_wr_addr = addr_ok ? haddr : wr_addr;
        next_flog = flog;
        next_preset = preset;
        next_view_index = view_index;
        next_active_fault = active_fault;
        next_time_mode = time_mode;
        next_lock_level = lock_level;
        next_key_code = key_code;
        next_unlocked = unlocked;
        next_rejected = rejected;
        next_base_freq = base_freq;
        next_hour_cnt = hour_cnt;
        next_hours = hours;
        next_days = days;
        // read mux, evaluated in the address phase
        next_hrdata = '0;
        if (addr_ok && !hwrite)
        begin
            if (haddr == mfll_pkg::OFS_FAULT1)
                next_hrdata = {24'h000000, flog[0]};
            else if (haddr == mfll_pkg::OFS_FAULT2)
                next_hrdata = {24'h000000, flog[1]};
            else if (haddr == mfll_pkg::OFS_FAULT3)
                next_hrdata = {24'h000000, flog[2]};
            else if (haddr == mfll_pkg::OFS_HOURS)
                next_hrdata = {27'h0000000, hours};
            else if (haddr == mfll_pkg::OFS_DAYS)
                next_hrdata = {16'h0000, days};
            else if (haddr == mfll_pkg::OFS_TIME_MODE)
                next_hrdata = {31'h00000000, time_mode};
            else if (haddr == mfll_pkg::OFS_LOCK)
                next_hrdata = {30'h00000000, lock_level};
            else if (haddr == mfll_pkg::OFS_KEY_CODE)
                next_hrdata = {31'h00000000, key_code != mfll_pkg::KEY_NONE}; // the key itself never reads back
            else if (haddr == mfll_pkg::OFS_STATUS)
                next_hrdata = {26'h0000000, nonclear, active_fault != mfll_pkg::FAULT_EMPTY,
                    view_index, rejected, unlocked};
            else if (haddr == mfll_pkg::OFS_BASE_FREQ)
                next_hrdata = {16'h0000, base_freq};
            else if ((haddr >= mfll_pkg::OFS_PRESET0) && (haddr <= mfll_pkg::OFS_PRESET_END))
                next_hrdata = {16'h0000, preset[haddr[4:2]]};
        end
        // accepted parameter writes; a refused one stores nothing
        if (wr_accept)
        begin
            if (is_preset)
                next_preset[preset_sel] = wd;
            else if (wr_addr == mfll_pkg::OFS_TIME_MODE)
                next_time_mode = wd[0];
            else if (wr_addr == mfll_pkg::OFS_LOCK)
                next_lock_level = wd[1:0];
            else if (wr_addr == mfll_pkg::OFS_KEY_CODE)
                next_key_code = wd;
            else if (wr_addr == mfll_pkg::OFS_BASE_FREQ)
                next_base_freq = wd;
            else if ((wd == mfll_pkg::RESTORE_50HZ) || (wd == mfll_pkg::RESTORE_60HZ))
            begin
                next_base_freq = (wd == mfll_pkg::RESTORE_50HZ) ? mfll_pkg::BASE_FREQ_50 : mfll_pkg::BASE_FREQ_60;
                next_time_mode = mfll_pkg::TMODE_POWER_ON;
                next_lock_level = mfll_pkg::LOCK_NONE;
                for (int i = 0; i < mfll_pkg::NUM_PRESETS; i++)
                    next_preset[i] = mfll_pkg::PRESET_DEFAULT;
            end
        end
        // key entry is always taken; a mismatch locks again
        if (wr_pend && (wr_addr == mfll_pkg::OFS_KEY_ENTRY))
            next_unlocked = (wd == key_code) && (key_code != mfll_pkg::KEY_NONE);
        // sticky refusal flag, write one clears, a new refusal wins
        if (wr_pend && (wr_addr == mfll_pkg::OFS_STATUS) && hwdata[mfll_pkg::ST_REJECTED])
            next_rejected = 1'b0;
        if (wr_pend && is_param && !wr_accept)
            next_rejected = 1'b1;
        // log view stepping
        if (in_log && up_hit)
            next_view_index = (view_index == 2'h0) ? 2'h2 : view_index - 2'h1;
        else if (in_log && down_hit)
            next_view_index = (view_index == 2'h2) ? 2'h0 : view_index + 2'h1;
        // reset key: clears log in log view, otherwise clears a clearable fault
        if (in_log && reset_hit)
        begin
            for (int i = 0; i < mfll_pkg::LOG_DEPTH; i++)
                next_flog[i] = mfll_pkg::FAULT_EMPTY;
        end
        else if (reset_hit && !nonclear)
            next_active_fault = mfll_pkg::FAULT_EMPTY;
        // a new fault pushes the stack down, and wins over a clear
        if (fault_pulse)
        begin
            next_flog[2] = flog[1];
            next_flog[1] = flog[0];
            next_flog[0] = fault_code;
            next_active_fault = fault_code;
        end
        // elapsed time
        if (counting)
        begin
            if (hour_cnt == CYCLES_PER_HOUR[mfll_pkg::HOUR_CNT_W-1:0] - 1'b1)
            begin
                next_hour_cnt = '0;
                if (hours == mfll_pkg::HOURS_MAX)
                begin
                    next_hours = '0;
                    if (days != mfll_pkg::DAYS_MAX)
                        next_days = days + 16'h0001;
                end
                else
                    next_hours = hours + 5'h01;
            end
            else
                next_hour_cnt = hour_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            for (int i = 0; i < mfll_pkg::LOG_DEPTH; i++)
                flog[i] <= mfll_pkg::FAULT_EMPTY;
            for (int i = 0; i < mfll_pkg::NUM_PRESETS; i++)
                preset[i] <= mfll_pkg::PRESET_DEFAULT;
            view_index <= 2'h0;
            active_fault <= mfll_pkg::FAULT_EMPTY;
            time_mode <= mfll_pkg::TMODE_POWER_ON;
            lock_level <= mfll_pkg::LOCK_NONE;
            key_code <= mfll_pkg::KEY_NONE;
            unlocked <= 1'b0;
            rejected <= 1'b0;
            base_freq <= mfll_pkg::BASE_FREQ_50;
            hour_cnt <= '0;
            hours <= '0;
            days <= '0;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            flog <= next_flog;
            preset <= next_preset;
            view_index <= next_view_index;
            active_fault <= next_active_fault;
            time_mode <= next_time_mode;
            lock_level <= next_lock_level;
            key_code <= next_key_code;
            unlocked <= next_unlocked;
            rejected <= next_rejected;
            base_freq <= next_base_freq;
            hour_cnt <= next_hour_cnt;
            hours <= next_hours;
            days <= next_days;
        end
    end

    // displayed entry comes straight from the log flops
    assign view_entry = flog[view_index];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    chk_log_push: assert property (fault_pulse |=> flog[0] == $past(fault_code)
        && flog[1] == $past(flog[0]) && flog[2] == $past(flog[1])) else $error("fault log push wrong");
    chk_log_newest: assert property (fault_pulse ##1 (!fault_pulse && !(in_log && reset_hit))
        |=> flog[0] == $past(flog[0])) else $error("newest entry changed without a fault");
    chk_log_clear: assert property (in_log && reset_hit && !fault_pulse
        |=> flog[0] == mfll_pkg::FAULT_EMPTY && flog[1] == mfll_pkg::FAULT_EMPTY
        && flog[2] == mfll_pkg::FAULT_EMPTY) else $error("log not emptied");
    chk_view_range: assert property (view_index <= 2'h2) else $error("view index out of range");
    chk_view_hold: assert property (!in_log |=> $stable(view_index)) else $error("view index moved");
    chk_hours_range: assert property (hours <= mfll_pkg::HOURS_MAX) else $error("hours above 23");
    chk_day_rollover: assert property (counting && hours == mfll_pkg::HOURS_MAX && $changed(next_hours)
        && days != mfll_pkg::DAYS_MAX |=> hours == 5'h00 && days == $past(days) + 16'h0001)
        else $error("day rollover wrong");
    chk_days_step: assert property ($changed(days)
        |-> $past(hours) == mfll_pkg::HOURS_MAX && hours == 5'h00) else $error("days moved without rollover");
    chk_mode_gate: assert property (time_mode == mfll_pkg::TMODE_RUNNING && !drive_running
        |=> $stable(hour_cnt)) else $error("time counted while stopped");
    chk_hour_step: assert property ($changed(hours) |-> $past(hour_cnt) == CYCLES_PER_HOUR - 1)
        else $error("hours moved early");
    chk_lock_block: assert property (wr_pend && is_preset && lock_level == mfll_pkg::LOCK_NO_PRESET
        |-> next_preset[preset_sel] == preset[preset_sel] ##1 rejected) else $error("locked preset written");
    chk_key_gate: assert property (wr_pend && key_code != mfll_pkg::KEY_NONE && !unlocked
        && wr_addr == mfll_pkg::OFS_BASE_FREQ |=> $stable(base_freq)) else $error("write without key");
    chk_restore_50: assert property (wr_accept && wr_addr == mfll_pkg::OFS_RESTORE
        && wd == mfll_pkg::RESTORE_50HZ |=> base_freq == mfll_pkg::BASE_FREQ_50
        && lock_level == mfll_pkg::LOCK_NONE) else $error("50 Hz restore not loaded");
    chk_restore_key: assert property (wr_pend && wr_addr == mfll_pkg::OFS_RESTORE && !key_ok
        |=> $stable(base_freq) && $stable(lock_level)) else $error("restore taken without key");
    chk_nonclear: assert property (nonclear && reset_hit && !fault_pulse |=> $stable(active_fault))
        else $error("protected fault cleared");
    chk_reject_keep: assert property (wr_pend && is_param && !wr_accept
        && wr_addr == mfll_pkg::OFS_KEY_CODE |=> $stable(key_code)) else $error("refused write stored");
    chk_key_store: assert property (wr_accept && wr_addr == mfll_pkg::OFS_KEY_CODE
        |=> key_code == $past(wd)) else $error("key code not stored");

endmodule

// ---- shared/mfll_pkg.sv ----
// constants, register map and fault codes of the maintenance fault log and lock block
package mfll_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 64'd200000000;   // ref_clk rate in hertz
    localparam longint HOUR_S = 64'd3600;        // one hour in seconds
    localparam longint CYCLES_PER_HOUR = CLK_HZ * HOUR_S;
    localparam int HOUR_CNT_W = 40;              // wide enough for one hour of cycles

    // ----------------------------------------------------------------
    // field widths and limits
    // ----------------------------------------------------------------
    localparam int CODE_W = 8;                   // fault code width
    localparam int LOG_DEPTH = 3;                // entries in the fault log
    localparam logic [4:0] HOURS_MAX = 5'h17;    // 23
    localparam logic [15:0] DAYS_MAX = 16'hFFFF; // 65535
    localparam int NUM_PRESETS = 8;              // preset speed slots

    // ----------------------------------------------------------------
    // modes and commands
    // ----------------------------------------------------------------
    localparam logic TMODE_POWER_ON = 1'b0;
    localparam logic TMODE_RUNNING = 1'b1;
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_NO_PRESET = 2'h1;
    localparam logic [1:0] LOCK_ONLY_PRESET = 2'h2;
    localparam logic [1:0] LOCK_ONLY_LOCK = 2'h3;
    localparam logic [15:0] KEY_NONE = 16'h0000;
    localparam logic [15:0] RESTORE_50HZ = 16'h047E;  // 1150
    localparam logic [15:0] RESTORE_60HZ = 16'h0488;  // 1160
    localparam logic [15:0] BASE_FREQ_50 = 16'h1388;  // 50.00 Hz in hundredths
    localparam logic [15:0] BASE_FREQ_60 = 16'h1770;  // 60.00 Hz in hundredths
    localparam logic [15:0] PRESET_DEFAULT = 16'h0000;

    // ----------------------------------------------------------------
    // fault codes; values arbitrary, zero marks an empty log entry
    // ----------------------------------------------------------------
    localparam logic [7:0] FAULT_EMPTY = 8'h00;
    localparam logic [7:0] STOPPED_OVERVOLTAGE_FAULT = 8'h01;
    localparam logic [7:0] STOPPED_UNDERVOLTAGE_FAULT = 8'h02;
    localparam logic [7:0] STOPPED_OVERHEAT_FAULT = 8'h03;
    localparam logic [7:0] RUNNING_OVERHEAT_FAULT = 8'h04;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_FAULT1 = 8'h00;
    localparam logic [7:0] OFS_FAULT2 = 8'h04;
    localparam logic [7:0] OFS_FAULT3 = 8'h08;
    localparam logic [7:0] OFS_HOURS = 8'h0C;
    localparam logic [7:0] OFS_DAYS = 8'h10;
    localparam logic [7:0] OFS_TIME_MODE = 8'h14;
    localparam logic [7:0] OFS_LOCK = 8'h18;
    localparam logic [7:0] OFS_KEY_CODE = 8'h1C;
    localparam logic [7:0] OFS_KEY_ENTRY = 8'h20;
    localparam logic [7:0] OFS_RESTORE = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_BASE_FREQ = 8'h30;
    localparam logic [7:0] OFS_PRESET0 = 8'h40;
    localparam logic [7:0] OFS_PRESET_END = 8'h5C;

    // status bit positions
    localparam int ST_UNLOCKED = 0;
    localparam int ST_REJECTED = 1;
    localparam int ST_VIEW_LO = 2;
    localparam int ST_FAULT_ACTIVE = 4;
    localparam int ST_NONCLEAR = 5;

endpackage

// ---- hdl/mfll_sync.sv ----
// two-flop synchroniser for keypad pins
`timescale 1ns/1ps

module mfll_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;  // first stage, read only by the second stage

    // ----------------------------------------------------------------
    // two stages, nothing else looks at the first one
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ---- verification/mfll_keypad.sv ----
// operator keypad and display panel model
`timescale 1ns/1ps
module mfll_keypad (
    input wire logic ref_clk,
    output logic key_up,
    output logic key_down,
    output logic key_reset,
    output logic log_shown
);
    // all keys released and no log view at power-up
    initial {key_up, key_down, key_reset, log_shown} = 4'h0;
    // switch the fault log view on or off
    task automatic show(input logic v);
        log_shown <= v;
        repeat (4) @(posedge ref_clk);
    endtask
    // key held 5 edges: the panel is slow, the sync needs 3 edges to act
    task automatic press(input logic [15:0] k);
        case (k)
            16'h0: key_up <= 1'h1;
            16'h1: key_down <= 1'h1;
            default: key_reset <= 1'h1;
        endcase
        repeat (5) @(posedge ref_clk);
        {key_up, key_down, key_reset} <= 3'h0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule

// ---- verification/mfll_tb.sv ----
// self-checking bench of the fault log, time counters and parameter lock
`timescale 1ns/1ps
module mfll_tb;
    logic ref_clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
    logic fault_pulse = 1'h0, drive_running = 1'h0, key_up, key_down, key_reset, log_shown;
    logic [7:0] haddr = 8'h0, fault_code = 8'h0, view_entry, active_fault;
    logic [1:0] htrans = 2'h0, view_index, vi = 2'h0, lv;
    logic [2:0] hsize = 3'h2; // whole words only
    logic [31:0] hwdata = 32'h0, hrdata, rd_q, q;
    logic [15:0] base_freq, ep = 16'h0, eb = 16'h1388, k;
    logic [23:0] lg = 24'h0; // expected log, newest in the low byte
    int mismatches = 0, checks = 0, t0, t1;
    assign hready = hreadyout; // single slave drives the bus ready
    // short hour keeps the run small
    mfll_top #(.CYCLES_PER_HOUR(8)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .key_up(key_up), .key_down(key_down), .key_reset(key_reset),
        .log_shown(log_shown), .fault_pulse(fault_pulse), .fault_code(fault_code), .drive_running(drive_running),
        .view_entry(view_entry), .view_index(view_index), .active_fault(active_fault), .base_freq(base_freq));
    mfll_keypad kp (.ref_clk(ref_clk), .key_up(key_up), .key_down(key_down), .key_reset(key_reset),
        .log_shown(log_shown));
    initial forever #2.5 ref_clk = ~ref_clk;
    // hold read data as it stood at the edge, avoiding a sampling race
    always @(posedge ref_clk) rd_q <= hrdata;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one single ahb-lite transfer, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
        do @(posedge ref_clk); while (hready !== 1'h1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge ref_clk); while (hready !== 1'h1);
        chk("hresp", 32'(hresp), 32'h0);
        hsel <= 1'h0;
        #1 q = rd_q;
        @(posedge ref_clk);
    endtask
    task automatic fault(input logic [7:0] c);
        {fault_pulse, fault_code} <= {1'h1, c};
        @(posedge ref_clk);
        fault_pulse <= 1'h0;
        repeat (2) @(posedge ref_clk);
        lg = {lg[15:0], c};
        chk("active_fault", active_fault, c);
    endtask
    task automatic chk_log;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'h0, 8'(4 * i), 32'h0);
            chk("fault_entry", q, lg[8*i+:8]);
        end
    endtask
    task automatic chk_par;
        bus(1'h0, mfll_pkg::OFS_PRESET0, 32'h0);
        chk("preset0", q, ep);
        bus(1'h0, mfll_pkg::OFS_BASE_FREQ, 32'h0);
        chk("base_freq", q, eb);
        chk("base_freq_pin", base_freq, eb);
    endtask
    // elapsed time in hours; also range checks on both counters
    task automatic hours_now(output int t);
        bus(1'h0, mfll_pkg::OFS_HOURS, 32'h0);
        chk("hours_max", 32'(q < 24), 32'h1);
        t = int'(q);
        bus(1'h0, mfll_pkg::OFS_DAYS, 32'h0);
        chk("days_width", q[31:16], 32'h0);
        t += 24 * int'(q);
    endtask
    // watchdog: whole run is a few hundred cycles, the limit is 40000
    initial
    begin
        #200000;
        mismatches++;
        close_out;
    end
    initial
    begin
        void'($urandom(32'h1E58));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        chk("base_freq_rst", base_freq, eb);
        repeat (4) fault(8'($urandom_range(5, 255)));
        chk_log;
        kp.show(1'h1);
        repeat (5)
        begin
            k = 16'($urandom_range(0, 1));
            kp.press(k);
            vi = k[0] ? (vi == 2'h2 ? 2'h0 : vi + 2'h1) : (vi == 2'h0 ? 2'h2 : vi - 2'h1);
            chk("view_index", view_index, vi);
            chk("view_entry", view_entry, lg[8*vi+:8]);
        end
        kp.press(16'h2);
        lg = 24'h0;
        chk_log;
        kp.show(1'h0);
        // four faults survive a manual reset, an ordinary one does not
        for (int c = 1; c < 6; c++)
        begin
            fault(c < 5 ? 8'(c) : 8'h55);
            kp.press(16'h2);
            chk("fault_kept", active_fault, c < 5 ? 8'(c) : 8'h0);
        end
        bus(1'h1, mfll_pkg::OFS_TIME_MODE, 32'h1);
        hours_now(t0);
        drive_running <= 1'h1;
        repeat (200) @(posedge ref_clk);
        drive_running <= 1'h0;
        hours_now(t1);
        chk("run_hours", t1 - t0, 32'd25);
        // power-on time between two frozen reads: 96 counted edges, twelve short hours
        bus(1'h1, mfll_pkg::OFS_TIME_MODE, 32'h0);
        repeat (93) @(posedge ref_clk);
        bus(1'h1, mfll_pkg::OFS_TIME_MODE, 32'h1);
        hours_now(t0);
        chk("power_hours", t0 - t1, 32'd12);
        // levels 0 1 3 2: level 2 refuses even the lock itself, so it comes last
        for (int l = 0; l < 4; l++)
        begin
            lv = 2'(l ^ (l >> 1));
            bus(1'h1, mfll_pkg::OFS_LOCK, {30'h0, lv});
            k = 16'($urandom);
            bus(1'h1, mfll_pkg::OFS_PRESET0, {16'h0, k});
            if (lv == 2'h0 || lv == 2'h2) ep = k;
            k = 16'($urandom);
            bus(1'h1, mfll_pkg::OFS_BASE_FREQ, {16'h0, k});
            if (lv < 2'h2) eb = k;
            chk_par;
        end
        bus(1'h1, mfll_pkg::OFS_LOCK, 32'h0);
        bus(1'h0, mfll_pkg::OFS_LOCK, 32'h0);
        chk("lock", q, 32'h2);
        // only a reset leaves level 2; it also brings back the reset values
        arst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        {ep, eb} = {16'h0, 16'h1388};
        chk_par;
        bus(1'h0, mfll_pkg::OFS_LOCK, 32'h0);
        chk("lock_rst", q, 32'h0);
        k = 16'($urandom_range(1, 65535));
        bus(1'h1, mfll_pkg::OFS_KEY_CODE, {16'h0, k});
        bus(1'h0, mfll_pkg::OFS_KEY_CODE, 32'h0);
        chk("key_set", q, 32'h1);
        bus(1'h1, mfll_pkg::OFS_KEY_ENTRY, {16'h0, ~k});
        bus(1'h1, mfll_pkg::OFS_BASE_FREQ, 32'h0100);
        bus(1'h1, mfll_pkg::OFS_RESTORE, 32'h0488);
        bus(1'h1, mfll_pkg::OFS_KEY_CODE, 32'h0);
        bus(1'h0, mfll_pkg::OFS_KEY_CODE, 32'h0);
        chk("key_kept", q, 32'h1);
        bus(1'h0, mfll_pkg::OFS_STATUS, 32'h0);
        chk("status", q, 32'h2);
        chk_par;
        bus(1'h1, mfll_pkg::OFS_KEY_ENTRY, {16'h0, k});
        bus(1'h1, mfll_pkg::OFS_RESTORE, 32'h0488);
        {ep, eb} = {16'h0, 16'h1770};
        chk_par;
        bus(1'h1, mfll_pkg::OFS_RESTORE, 32'h047E);
        eb = 16'h1388;
        chk_par;
        close_out;
    end
endmodule
